// ==== rtl/cts_pkg.sv ====
// Shared constants of the charge termination sequencer.
// Assumes an 800 Hz oscillator tick is the time base for every phase length.
package cts_pkg;
   // Oscillator rate and phase lengths, printed figures in ms
   localparam int OSC_HZ = 800;
   localparam int T_PERIOD_MS = 20480;
   localparam int T_ON_MS = 5120;
   localparam int T_BREAK_MS = 2560;
   localparam int T_SETTLE_MS = 1280;
   localparam int T_PAUSE_DLY_MS = 40;
   localparam int T_PAUSE_LEN_MS = 10;
   localparam longint T_TRICKLE_MS = 1310720;
   localparam longint T_TOPOFF_MS = 1200000;
   localparam longint T_FORM_MS = 300000;
   // Oscillator cycle counts derived from the times above
   localparam int PERIOD_CYC = T_PERIOD_MS * OSC_HZ / 1000;
   localparam int ON_CYC = T_ON_MS * OSC_HZ / 1000;
   localparam int BREAK_CYC = T_BREAK_MS * OSC_HZ / 1000;
   localparam int SETTLE_CYC = T_SETTLE_MS * OSC_HZ / 1000;
   localparam int PAUSE_DLY_CYC = T_PAUSE_DLY_MS * OSC_HZ / 1000;
   localparam int PAUSE_LEN_CYC = T_PAUSE_LEN_MS * OSC_HZ / 1000;
   localparam int TRICKLE_CYC = int'(T_TRICKLE_MS * OSC_HZ / 1000);
   localparam int TOPOFF_CYC = int'(T_TOPOFF_MS * OSC_HZ / 1000);
   localparam int FORM_CYC = int'(T_FORM_MS * OSC_HZ / 1000);
   localparam int TIMER_W = 21;
   // Converter layout: 5-bit coarse over 5-bit fine
   localparam int COARSE_W = 5;
   localparam int FINE_W = 5;
   localparam int CODE_W = COARSE_W + FINE_W;
   // Slope counter and stop thresholds, in steps of 6.5 mV
   localparam int SLOPE_W = 4;
   localparam int SLOPE_HALF = 8;
   localparam int SLOPE_LIMIT = 2;
   localparam int NEG_STEP_LSB = 2;
   localparam int NEG_STEP_RUNS = 3;
   // Charging phases
   typedef enum logic [1:0] {CTS_FAST, CTS_TOPOFF, CTS_TRICKLE} cts_phase_t;
endpackage

// ==== rtl/cts_adc.sv ====
// Coarse/fine counting converter, one step per oscillator tick.
// Assumes a synchronised comparator: high while battery is above the DAC level.
`timescale 1ns/10ps
module cts_adc (
   // Clock and control
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_tick,
   input wire logic i_start,
   // Comparator
   input wire logic i_above,
   // Results
   output logic [cts_pkg::CODE_W-1:0] o_dac_code,
   output logic [cts_pkg::CODE_W-1:0] o_result,
   output logic o_done
);
   typedef enum logic [1:0] {CTS_A_IDLE, CTS_A_COARSE, CTS_A_FINE} cts_adc_st_t;
   cts_adc_st_t st_q;
   logic [cts_pkg::COARSE_W-1:0] crs_q;
   logic [cts_pkg::FINE_W-1:0] fin_q;

   // Linear count: coarse up until the level is passed, then fine under it
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_q <= CTS_A_IDLE;
         crs_q <= '0;
         fin_q <= '0;
         o_result <= '0;
         o_done <= 1'b0;
      end else if (i_ce) begin
         o_done <= 1'b0;
         case (st_q)
            CTS_A_IDLE: begin
               if (i_start) begin
                  crs_q <= '0;
                  fin_q <= '0;
                  st_q <= CTS_A_COARSE;
               end
            end
            CTS_A_COARSE: begin
               if (i_tick) begin
                  if (!i_above) begin
                     // Step back one coarse level, fine stage fills the gap
                     if (crs_q != '0) crs_q <= crs_q - 1'b1;
                     st_q <= CTS_A_FINE;
                  end else if (&crs_q) begin
                     st_q <= CTS_A_FINE;
                  end else begin
                     crs_q <= crs_q + 1'b1;
                  end
               end
            end
            CTS_A_FINE: begin
               if (i_tick) begin
                  if (!i_above || &fin_q) begin
                     // Trailing edge of the fine count ends the conversion
                     o_result <= (!i_above && fin_q != '0) ? {crs_q, fin_q - 1'b1}
                                                           : {crs_q, fin_q};
                     o_done <= 1'b1;
                     st_q <= CTS_A_IDLE;
                  end else begin
                     fin_q <= fin_q + 1'b1;
                  end
               end
            end
            default: st_q <= CTS_A_IDLE;
         endcase
      end
   end

   // DAC level follows the counters
   always_ff @(posedge i_clk) begin
      if (i_rst) o_dac_code <= '0;
      else if (i_ce) o_dac_code <= (st_q == CTS_A_FINE) ? {crs_q, fin_q}
                                                       : {crs_q, {cts_pkg::FINE_W{1'b0}}};
   end
endmodule

// ==== rtl/cts_top.sv ====
// Charge termination sequencer: breaks, measurement, stop checks, duty phases.
// Assumes the oscillator, comparator and overvoltage pins are asynchronous.
//
// Functional notes
// - Fast charge ends on curvature or negative step
// - Top-off delivers 5.12 s per 20.48 s
// - Top-off lasts at most 20 minutes
// - Both stop checks stay active in top-off
// - Trickle 5.12 s per 1310.72 s, indefinitely
// - Converter has 5-bit coarse, 5-bit fine stages
// - Linear count converter, 6.5 mV steps
// - Sampling only inside 2.56 s charge break
// - Break is 1.28 s settle then 1.28 s conversion
// - Slope counter counts up 8, down 8
// - After 16 cycles compare with window start
// - Difference over two LSB ends fast charge or top-off
// - Second slope counter runs offset by 8
// - Threshold matches 4.8 mV per minute squared
// - Battery input near 5 V acts as reset
// - Slope counter 4 bits, steps per fine conversion
// - Negative step: 13 mV low, three consecutive
// - Pause pulse 10 ms, 40 ms into break
// - Curvature check off first 5 minutes
`timescale 1ns/10ps
module cts_top #(
   parameter int PERIOD_CYC = cts_pkg::PERIOD_CYC,
   parameter int TRICKLE_CYC = cts_pkg::TRICKLE_CYC,
   parameter int TOPOFF_CYC = cts_pkg::TOPOFF_CYC,
   parameter int FORM_CYC = cts_pkg::FORM_CYC
) (
   // Clock, reset, enable
   input wire logic I_SYS_CLK,
   input wire logic I_SRST,
   input wire logic I_CE,
   // Analogue front end
   input wire logic I_OSC,
   input wire logic I_BATTERY_SENSE_ABOVE,
   input wire logic I_BATTERY_SENSE_OVV,
   // Charge control
   output logic O_CHARGE_EN,
   output logic O_CHARGE_PAUSE_OUTPUT,
   output logic [cts_pkg::CODE_W-1:0] O_DAC_CODE,
   // Status
   output logic [1:0] O_PHASE,
   output logic [cts_pkg::CODE_W-1:0] O_SAMPLE,
   output logic O_NEGATIVE_STEP_TRIP,
   output logic O_CURVATURE_TRIP,
   output logic O_OVV_RESET
);
   localparam int TW = cts_pkg::TIMER_W;
   localparam int SW = cts_pkg::SLOPE_W;
   localparam int CW = cts_pkg::CODE_W;

   logic osc_s1_q, osc_s2_q, osc_s3_q;
   logic abv_s1_q, abv_s2_q;
   logic ovv_s1_q, ovv_s2_q;
   logic tick, rst;
   cts_pkg::cts_phase_t phase_q;
   logic [TW-1:0] ph_q;
   logic [TW-1:0] phase_time_q;
   logic curv_en;
   logic adc_start, adc_done;
   logic [CW-1:0] adc_result;
   logic [CW-1:0] prev_q, peak_q;
   logic prev_vld_q;
   logic [1:0] neg_runs_q;
   logic [3:0] meas_q;
   logic signed [SW-1:0] slope_q [2];
   logic signed [SW-1:0] start_q [2];
   logic [1:0] win_full_q;
   logic neg_hit, curv_hit, stop_hit;
   logic signed [SW-1:0] delta;

   // Clamp a sample difference into the slope counter's range
   function automatic logic signed [SW-1:0] clamp_delta(input logic [CW-1:0] a,
                                                         input logic [CW-1:0] b);
      logic signed [CW:0] d;
      d = $signed({1'b0, a}) - $signed({1'b0, b});
      if (d > 7) clamp_delta = 4'sh7;
      else if (d < -7) clamp_delta = -4'sh7;
      else clamp_delta = d[SW-1:0];
   endfunction

   // Saturating up or down step of a slope counter
   function automatic logic signed [SW-1:0] slope_step(input logic signed [SW-1:0] c,
                                                        input logic signed [SW-1:0] d,
                                                        input logic up);
      logic signed [SW+1:0] s;
      s = up ? (SW+2)'(c) + (SW+2)'(d) : (SW+2)'(c) - (SW+2)'(d);
      if (s > 7) slope_step = 4'sh7;
      else if (s < -8) slope_step = -4'sh8;
      else slope_step = s[SW-1:0];
   endfunction

   // Two flip-flops on the oscillator, comparator and overvoltage pins before use
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
         abv_s1_q <= 1'b0;
         abv_s2_q <= 1'b0;
         ovv_s1_q <= 1'b0;
         ovv_s2_q <= 1'b0;
      end else if (I_CE) begin
         osc_s1_q <= I_OSC;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
         abv_s1_q <= I_BATTERY_SENSE_ABOVE;
         abv_s2_q <= abv_s1_q;
         ovv_s1_q <= I_BATTERY_SENSE_OVV;
         ovv_s2_q <= ovv_s1_q;
      end
   end

   // Rising oscillator edge is the time base
   assign tick = osc_s2_q & ~osc_s3_q;
   // Overvoltage on the battery input restarts everything
   assign rst = I_SRST | ovv_s2_q;
   assign O_OVV_RESET = ovv_s2_q;

   // Position inside the current charge period
   always_ff @(posedge I_SYS_CLK) begin
      if (rst) begin
         ph_q <= '0;
      end else if (I_CE && tick) begin
         if (phase_q == cts_pkg::CTS_TRICKLE)
            ph_q <= (ph_q >= TW'(TRICKLE_CYC - 1)) ? '0 : ph_q + 1'b1;
         else
            ph_q <= (ph_q >= TW'(PERIOD_CYC - 1)) ? '0 : ph_q + 1'b1;
      end
   end

   // Time spent in the present phase, saturating
   always_ff @(posedge I_SYS_CLK) begin
      if (rst) begin
         phase_time_q <= '0;
      end else if (I_CE) begin
         if (stop_hit || (phase_q == cts_pkg::CTS_TOPOFF && tick
                          && phase_time_q >= TW'(TOPOFF_CYC - 1)))
            phase_time_q <= '0;
         else if (tick && !(&phase_time_q))
            phase_time_q <= phase_time_q + 1'b1;
      end
   end

   // Formation window keeps the curvature check quiet at first
   assign curv_en = (phase_q == cts_pkg::CTS_TOPOFF)
                    || (phase_q == cts_pkg::CTS_FAST
                        && phase_time_q >= TW'(FORM_CYC));

   // Phase sequence: fast, top-off, trickle
   always_ff @(posedge I_SYS_CLK) begin
      if (rst) begin
         phase_q <= cts_pkg::CTS_FAST;
      end else if (I_CE) begin
         case (phase_q)
            cts_pkg::CTS_FAST: begin
               if (stop_hit) phase_q <= cts_pkg::CTS_TOPOFF;
            end
            cts_pkg::CTS_TOPOFF: begin
               if (stop_hit) phase_q <= cts_pkg::CTS_TRICKLE;
               else if (tick && phase_time_q >= TW'(TOPOFF_CYC - 1))
                  phase_q <= cts_pkg::CTS_TRICKLE;
            end
            cts_pkg::CTS_TRICKLE: phase_q <= cts_pkg::CTS_TRICKLE;
            default: phase_q <= cts_pkg::CTS_FAST;
         endcase
      end
   end

   // Current gate and pause pulse; breaks only where sampling happens
   always_ff @(posedge I_SYS_CLK) begin
      if (rst) begin
         O_CHARGE_EN <= 1'b0;
         O_CHARGE_PAUSE_OUTPUT <= 1'b0;
      end else if (I_CE) begin
         case (phase_q)
            cts_pkg::CTS_FAST:
               O_CHARGE_EN <= ph_q >= TW'(cts_pkg::BREAK_CYC);
            cts_pkg::CTS_TOPOFF:
               O_CHARGE_EN <= ph_q >= TW'(cts_pkg::BREAK_CYC)
                  && ph_q < TW'(cts_pkg::BREAK_CYC + cts_pkg::ON_CYC);
            cts_pkg::CTS_TRICKLE:
               O_CHARGE_EN <= ph_q < TW'(cts_pkg::ON_CYC);
            default: O_CHARGE_EN <= 1'b0;
         endcase
         O_CHARGE_PAUSE_OUTPUT <= phase_q != cts_pkg::CTS_TRICKLE
            && ph_q >= TW'(cts_pkg::PAUSE_DLY_CYC)
            && ph_q < TW'(cts_pkg::PAUSE_DLY_CYC + cts_pkg::PAUSE_LEN_CYC);
      end
   end

   // Conversion starts once the settling half of the break is over
   assign adc_start = tick && phase_q != cts_pkg::CTS_TRICKLE
                      && ph_q == TW'(cts_pkg::SETTLE_CYC);

   // Converter; at most 64 ticks, well inside the 1.28 s window
   cts_adc u_adc (
      .i_clk(I_SYS_CLK),
      .i_rst(rst),
      .i_ce(I_CE),
      .i_tick(tick),
      .i_start(adc_start),
      .i_above(abv_s2_q),
      .o_dac_code(O_DAC_CODE),
      .o_result(adc_result),
      .o_done(adc_done)
   );

   // Negative step: a sample well below the stored peak
   assign neg_hit = adc_done && prev_vld_q
                    && (CW+1)'(adc_result) + (CW+1)'(cts_pkg::NEG_STEP_LSB)
                       <= (CW+1)'(peak_q);
   assign delta = prev_vld_q ? clamp_delta(adc_result, prev_q) : '0;

   // Sample history and peak
   always_ff @(posedge I_SYS_CLK) begin
      if (rst) begin
         prev_q <= '0;
         peak_q <= '0;
         prev_vld_q <= 1'b0;
         O_SAMPLE <= '0;
      end else if (I_CE && adc_done) begin
         prev_q <= adc_result;
         prev_vld_q <= 1'b1;
         O_SAMPLE <= adc_result;
         if (!prev_vld_q || adc_result > peak_q) peak_q <= adc_result;
      end
   end

   // Consecutive low samples; one normal sample clears the run
   // Stop clear sits under the enable so a held done pulse cannot wipe the run
   always_ff @(posedge I_SYS_CLK) begin
      if (rst) begin
         neg_runs_q <= '0;
      end else if (I_CE) begin
         if (stop_hit) begin
            neg_runs_q <= '0;
         end else if (adc_done) begin
            if (!neg_hit) neg_runs_q <= '0;
            else if (neg_runs_q != 2'(cts_pkg::NEG_STEP_RUNS)) neg_runs_q <= neg_runs_q + 1'b1;
         end
      end
   end

   // Measurement index shared by both slope windows
   always_ff @(posedge I_SYS_CLK) begin
      if (rst) meas_q <= '0;
      else if (I_CE && adc_done) meas_q <= meas_q + 1'b1;
   end

   // Two slope counters, the second half a window behind the first
   always_ff @(posedge I_SYS_CLK) begin
      if (rst) begin
         for (int k = 0; k < 2; k++) begin
            slope_q[k] <= '0;
            start_q[k] <= '0;
         end
         win_full_q <= '0;
      end else if (I_CE && adc_done) begin
         for (int k = 0; k < 2; k++) begin
            logic [3:0] pos;
            pos = meas_q - 4'(k * cts_pkg::SLOPE_HALF);
            if (pos == 4'h0) begin
               start_q[k] <= slope_q[k];
               win_full_q[k] <= 1'b1;
            end
            slope_q[k] <= slope_step(slope_q[k], delta,
                                     pos < 4'(cts_pkg::SLOPE_HALF));
         end
      end
   end

   // Rising curvature drives the count below its start value
   always_comb begin
      curv_hit = 1'b0;
      for (int k = 0; k < 2; k++) begin
         if (adc_done && win_full_q[k]
             && meas_q == 4'(k * cts_pkg::SLOPE_HALF)
             && (6'(start_q[k]) - 6'(slope_q[k])) > 6'sd2
             && $signed(6'(start_q[k]) - 6'(slope_q[k])) > $signed(6'(cts_pkg::SLOPE_LIMIT)))
            curv_hit = curv_en;
      end
   end

   // Either criterion ends the running phase
   assign stop_hit = phase_q != cts_pkg::CTS_TRICKLE
                     && (curv_hit || (neg_hit
                         && neg_runs_q == 2'(cts_pkg::NEG_STEP_RUNS - 1)));

   // Sticky trip flags and phase report
   always_ff @(posedge I_SYS_CLK) begin
      if (rst) begin
         O_NEGATIVE_STEP_TRIP <= 1'b0;
         O_CURVATURE_TRIP <= 1'b0;
         O_PHASE <= 2'h0;
      end else if (I_CE) begin
         if (stop_hit && !curv_hit) O_NEGATIVE_STEP_TRIP <= 1'b1;
         if (stop_hit && curv_hit) O_CURVATURE_TRIP <= 1'b1;
         O_PHASE <= phase_q;
      end
   end
endmodule

// ==== sim/cts_batt_model.sv ====
// Battery pack model: comparator against the DAC level, overvoltage flag.
// Assumes the bench sets the pack level in converter steps.
`timescale 1ns/10ps
module cts_batt_model (
   // From the sequencer
   input wire logic [cts_pkg::CODE_W-1:0] i_dac_code,
   // Pack state from the bench
   input wire logic [cts_pkg::CODE_W-1:0] i_level,
   input wire logic i_over,
   // Comparator and overvoltage lines
   output logic o_above,
   output logic o_ovv
);
   // At or above the DAC level; one step is 6.5 mV
   assign o_above = i_level >= i_dac_code;
   // Pack near 5 V seen as overvoltage
   assign o_ovv = i_over;
endmodule

// ==== sim/cts_top_chk.sv ====
// Timing checker for the sequencer top level.
// Assumes I_OSC is a steady square wave of several clocks per half period.
`timescale 1ns/10ps
module cts_top_chk #(
   parameter int PERIOD_CYC = 16384
) (
   // Clock, reset, enable, oscillator
   input wire logic I_SYS_CLK,
   input wire logic I_SRST,
   input wire logic I_CE,
   input wire logic I_OSC,
   // Watched outputs
   input wire logic O_CHARGE_EN,
   input wire logic O_CHARGE_PAUSE_OUTPUT,
   input wire logic [1:0] O_PHASE,
   input wire logic [cts_pkg::CODE_W-1:0] O_SAMPLE,
   input wire logic O_NEGATIVE_STEP_TRIP,
   input wire logic O_CURVATURE_TRIP,
   input wire logic O_OVV_RESET
);
   logic [2:0] osc_q;
   logic pause_q;
   logic tick;
   int since_q = 0;
   int on_q = 0;
   // Own tick, same pipeline depth as the design's; only enabled ticks count
   assign tick = osc_q[1] & ~osc_q[2];
   always_ff @(posedge I_SYS_CLK) begin
      osc_q <= {osc_q[1:0], I_OSC};
      pause_q <= O_CHARGE_PAUSE_OUTPUT;
   end
   // Ticks since the pause pulse rose
   always_ff @(posedge I_SYS_CLK) begin
      if (O_CHARGE_PAUSE_OUTPUT && !pause_q) begin
         since_q <= int'(tick && I_CE);
      end else if (tick && I_CE) begin
         since_q <= since_q + 1;
      end
   end
   // Ticks with charge current on
   always_ff @(posedge I_SYS_CLK) begin
      if (!O_CHARGE_EN) begin
         on_q <= 0;
      end else if (tick && I_CE) begin
         on_q <= on_q + 1;
      end
   end
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_SRST || O_OVV_RESET);
   property p_pause_len;
      $fell(O_CHARGE_PAUSE_OUTPUT) ##1 O_PHASE != 2'h2 |-> $past(since_q) == 8;
   endproperty
   a_pause_len: assert property (p_pause_len) else $error("pause length");
   property p_en_delay;
      $rose(O_CHARGE_EN) ##1 O_PHASE != 2'h2 |-> $past(since_q) == 2016;
   endproperty
   a_en_delay: assert property (p_en_delay) else $error("charge restart");
   property p_fast_len;
      $fell(O_CHARGE_EN) ##1 O_PHASE == 2'h0 |-> $past(on_q) == PERIOD_CYC - 2048;
   endproperty
   a_fast_len: assert property (p_fast_len) else $error("fast on time");
   property p_topoff_len;
      $fell(O_CHARGE_EN) ##1 O_PHASE == 2'h1 |-> $past(on_q) == 4096;
   endproperty
   a_topoff_len: assert property (p_topoff_len) else $error("top-off on time");
   property p_sample_in_break;
      $changed(O_SAMPLE) |-> !O_CHARGE_EN && since_q >= 992 && since_q <= 1057;
   endproperty
   a_sample_in_break: assert property (p_sample_in_break) else $error("sample time");
   property p_phase_order;
      $changed(O_PHASE) |-> O_PHASE == $past(O_PHASE) + 2'h1;
   endproperty
   a_phase_order: assert property (p_phase_order) else $error("phase order");
   property p_trip_phase;
      $rose(O_NEGATIVE_STEP_TRIP) || $rose(O_CURVATURE_TRIP) |-> ##[0:2] O_PHASE != 2'h0;
   endproperty
   a_trip_phase: assert property (p_trip_phase) else $error("trip kept fast");
   property p_trickle_quiet;
      $past(O_PHASE) == 2'h2 && O_PHASE == 2'h2 |-> $stable(O_SAMPLE);
   endproperty
   a_trickle_quiet: assert property (p_trickle_quiet) else $error("trickle sample");
   property p_ovv;
      disable iff (I_SRST) O_OVV_RESET [*3] |-> !O_CHARGE_EN && O_PHASE == 2'h0;
   endproperty
   a_ovv: assert property (p_ovv) else $error("overvoltage not reset");
endmodule
bind cts_top cts_top_chk #(.PERIOD_CYC(PERIOD_CYC)) u_chk (
   .I_SYS_CLK(I_SYS_CLK), .I_SRST(I_SRST), .I_CE(I_CE), .I_OSC(I_OSC),
   .O_CHARGE_EN(O_CHARGE_EN), .O_CHARGE_PAUSE_OUTPUT(O_CHARGE_PAUSE_OUTPUT),
   .O_PHASE(O_PHASE), .O_SAMPLE(O_SAMPLE), .O_NEGATIVE_STEP_TRIP(O_NEGATIVE_STEP_TRIP),
   .O_CURVATURE_TRIP(O_CURVATURE_TRIP), .O_OVV_RESET(O_OVV_RESET));

// ==== sim/testbench.sv ====
// Self-checking bench for the charge termination sequencer.
// Assumes the battery model and checker files are compiled before it.
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
   localparam int TK = 4; // Clocks per oscillator tick
   localparam int PER = 6160; // Short period, must stay above 6144
   localparam logic [cts_pkg::CODE_W-1:0] V0 = 10'h2a5;
   logic I_SYS_CLK = 1'b0;
   logic I_SRST = 1'b1;
   logic I_CE = 1'b1;
   logic I_OSC = 1'b0;
   logic over = 1'b0;
   logic [cts_pkg::CODE_W-1:0] level = V0;
   logic [cts_pkg::CODE_W-1:0] dac, smp;
   logic [1:0] phase;
   logic above, ovv, en, pause, neg, curv, ovr;
   int n_errors = 0;
   int checks_done = 0;
   int osc_n = 0;
   // Clock and a 4-clock oscillator, launched off the sampling edge
   always #4 I_SYS_CLK = ~I_SYS_CLK;
   always @(negedge I_SYS_CLK) begin
      osc_n <= osc_n + 1;
      if (osc_n[0]) I_OSC <= ~I_OSC;
   end
   cts_batt_model batt (.i_dac_code(dac), .i_level(level), .i_over(over),
      .o_above(above), .o_ovv(ovv));
   // Top-off limit kept beyond the run so it never cuts the on window
   cts_top #(.PERIOD_CYC(PER), .TOPOFF_CYC(30000), .FORM_CYC(100)) dut (
      .I_SYS_CLK(I_SYS_CLK), .I_SRST(I_SRST), .I_CE(I_CE), .I_OSC(I_OSC),
      .I_BATTERY_SENSE_ABOVE(above), .I_BATTERY_SENSE_OVV(ovv),
      .O_CHARGE_EN(en), .O_CHARGE_PAUSE_OUTPUT(pause), .O_DAC_CODE(dac),
      .O_PHASE(phase), .O_SAMPLE(smp), .O_NEGATIVE_STEP_TRIP(neg),
      .O_CURVATURE_TRIP(curv), .O_OVV_RESET(ovr));
   // Clocks until pause (sel) or charge gate reaches a level, bounded
   task automatic span(input bit sel, input logic lvl, output int n);
      n = 0;
      while (((sel ? pause : en) !== lvl) && n < 40000) begin
         @(negedge I_SYS_CLK);
         n++;
      end
      `CHK(n < 40000, 1'b1)
   endtask
   task automatic report_and_stop;
      if (n_errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Everything idle and in fast phase while reset is held
   task automatic t_reset;
      `CHK({en, pause, neg, curv, ovr}, 5'h00)
      `CHK(phase, 2'h0)
      `CHK(smp, 10'h000)
   endtask
   // First break: pulse, settle, conversion, then the fast on window
   task automatic t_first_period;
      int n;
      span(1'b1, 1'b1, n);
      // Enable low for whole oscillator periods: the pulse must stretch by that much
      I_CE = 1'b0;
      repeat (4 * TK) @(negedge I_SYS_CLK);
      I_CE = 1'b1;
      span(1'b1, 1'b0, n);
      `CHK(n, 8 * TK)
      `CHK(en, 1'b0)
      span(1'b0, 1'b1, n);
      `CHK(n, (2048 - 40) * TK)
      `CHK(smp, V0)
      `CHK(dac[9:5], V0[9:5])
      level = V0 - 10'h003;
      span(1'b0, 1'b0, n);
      `CHK(n, (PER - 2048) * TK)
   endtask
   // Three low samples in a row end fast charge, then top-off duty
   task automatic t_negative_step;
      int n;
      repeat (2) begin
         span(1'b0, 1'b1, n);
         `CHK(smp, V0 - 10'h003)
         `CHK(neg, 1'b0)
         span(1'b0, 1'b0, n);
      end
      span(1'b0, 1'b1, n);
      `CHK(neg, 1'b1)
      `CHK(curv, 1'b0)
      `CHK(phase, 2'h1)
      span(1'b0, 1'b0, n);
      `CHK(n, 4096 * TK)
   endtask
   // Overvoltage clears the sequencer like a reset
   task automatic t_overvoltage;
      over = 1'b1;
      repeat (6) @(negedge I_SYS_CLK);
      `CHK(ovr, 1'b1)
      `CHK({en, neg, phase}, 4'h0)
      over = 1'b0;
      repeat (6) @(negedge I_SYS_CLK);
      `CHK(ovr, 1'b0)
   endtask
   // Main sequence
   initial begin
      repeat (10) @(negedge I_SYS_CLK);
      t_reset;
      I_SRST = 1'b0;
      t_first_period;
      t_negative_step;
      t_overvoltage;
      report_and_stop;
   end
   // Hang guard, a few percent above the expected run
   initial begin
      repeat (104000) @(posedge I_SYS_CLK);
      n_errors++;
      report_and_stop;
   end
endmodule
